// [design/degd_pkg.sv]
// degd_pkg: register map, reset values and carriers of the deviation guard
// assumes: 32-bit apb data, one aligned word per register index
package degd_pkg;

  localparam int unsigned ADDR_W = 12;
  typedef logic [ADDR_W-1:0] degd_addr_t;

  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_CPR    = 10'h190;
  localparam logic [9:0] IDX_LIMIT  = 10'h192;
  localparam logic [9:0] IDX_TC     = 10'h196;
  localparam logic [9:0] IDX_SWCLR  = 10'h1A8;
  localparam logic [9:0] IDX_REVS   = 10'h1AA;
  localparam logic [9:0] IDX_CTRL   = 10'h1B0;
  localparam logic [9:0] IDX_STAT   = 10'h1B1;
  localparam logic [9:0] IDX_ACCERR = 10'h1B2;
  localparam logic [9:0] IDX_INSTDV = 10'h1B3;
  localparam logic [9:0] IDX_MONDEV = 10'h1B4;
  localparam logic [9:0] IDX_POSERR = 10'h1B5;

  // reset values
  localparam logic [31:0] RST_LIMIT = 32'h0000_7530;
  localparam logic [15:0] RST_TC    = 16'h0064;
  localparam logic [15:0] RST_SWCLR = 16'h0000;
  localparam logic [15:0] RST_REVS  = 16'h0000;
  localparam logic [31:0] RST_CPR   = 32'h0100_0000;

  // field positions
  localparam int unsigned CTRL_FULL_EN = 0;
  localparam int unsigned CTRL_INDEX   = 1;
  localparam int unsigned STAT_ALARM   = 0;
  localparam int unsigned STAT_FULL    = 1;
  localparam int unsigned SWCLR_X      = 0;

  // main encoder counts per motor revolution, as a shift
  localparam int unsigned REV_SHIFT = 24;

  // filter tick
  localparam int unsigned CLK_HZ    = 100_000_000;
  localparam int unsigned TICK_US   = 1000;
  localparam int unsigned TICK_CYC  = CLK_HZ / 1_000_000 * TICK_US;

  typedef enum logic [1:0] {
    DEGD_LOOP_HALF = 2'b00,
    DEGD_LOOP_FULL = 2'b01
  } degd_loop_e;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    degd_addr_t  paddr;
    logic [31:0] pwdata;
  } degd_apb_req_s;

  typedef struct packed {
    logic signed [31:0] main_pos;
    logic signed [31:0] aux_pos;
    logic signed [31:0] cmd_pos;
  } degd_enc_s;

endpackage : degd_pkg

// [design/degd_guard.sv]
// degd_guard: dual encoder deviation guard with feedback blending
// assumes: encoder positions and inputs synchronous to clk_in
//
// How it works
// - the alarm rises when the monitored deviation magnitude exceeds the limit.
// - deviation is main times counts-per-rev over 2^24 minus aux.
// - the monitored deviation returns to zero every N motor revs.
// - homing zeroes accumulated error but not the monitored deviation.
// - accumulated error and instantaneous deviation are both readable.
// - a filter time constant of zero bypasses blending; default 100 ms.
// - blending follows the motor on transients, settles to the aux.
// - velocity uses motor feedback, position aux only in full loop.
// - error-clear field 0 clears the error on half-to-full switch.
// - error-clear field 1 keeps the error so the axis corrects it.
// - indexing mode always clears the error on any loop switch.
// - a revolution count of zero disables revolution clearing.
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module degd_guard #(
  parameter int unsigned TICK_CYCLES = degd_pkg::TICK_CYC
) (
  input  wire logic                   clk_in,
  input  wire logic                   sys_rst_in,
  input  wire degd_pkg::degd_apb_req_s apb_in,
  output logic                        pready_out,
  output logic                        pslverr_out,
  output logic [31:0]                 prdata_out,
  input  wire degd_pkg::degd_enc_s     enc_in,
  input  wire logic                   loop_select_in,
  input  wire logic                   homing_in,
  output logic                        excess_deviation_alarm_out,
  output logic                        full_loop_active_out,
  output logic signed [31:0]          pos_fb_out,
  output logic signed [31:0]          vel_fb_out,
  output logic signed [31:0]          pos_err_out
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] abs32(input logic signed [31:0] v);
    return v[31] ? 32'(-v) : 32'(v);
  endfunction

  function automatic logic [9:0] word_idx(input degd_pkg::degd_addr_t a);
    return a[degd_pkg::ADDR_W-1:2];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register file
  logic [31:0]        cpr_q, cpr_d;
  logic [31:0]        limit_q, limit_d;
  logic [15:0]        tc_q, tc_d;
  logic [15:0]        swclr_q, swclr_d;
  logic [15:0]        revs_q, revs_d;
  logic               full_en_q, full_en_d;
  logic               index_q, index_d;
  logic               alarm_q, alarm_d;
  logic [31:0]        prdata_q, prdata_d;
  logic               slverr_q, slverr_d;
  logic               wr_acc, rd_setup, mapped;
  logic [9:0]         idx;

  // guard state
  degd_pkg::degd_loop_e loop_q, loop_d;
  logic signed [31:0] scaled_main;
  logic signed [63:0] prod;
  logic signed [31:0] dev;
  logic signed [31:0] dev_base_q, dev_base_d;
  logic signed [31:0] mon_q, mon_d;
  logic signed [31:0] rev_ref_q, rev_ref_d;
  logic signed [31:0] acc_base_q, acc_base_d;
  logic signed [31:0] acc_err_q, acc_err_d;
  logic signed [31:0] inst_q, inst_d;
  logic signed [31:0] lpf_q, lpf_d;
  logic signed [31:0] fb_q, fb_d;
  logic signed [31:0] vel_q, vel_d;
  logic signed [31:0] err_ofs_q, err_ofs_d;
  logic signed [31:0] perr_q, perr_d;
  logic [31:0]        tick_q, tick_d;
  logic [31:0]        revs_done;
  logic               rev_hit, want_full, sw_any, sw_up, clr_sw;
  logic               alarm_clr;

  assign idx      = word_idx(apb_in.paddr);
  assign wr_acc   = apb_in.psel & apb_in.penable & apb_in.pwrite;
  assign rd_setup = apb_in.psel & ~apb_in.penable;
  assign mapped   = (idx == degd_pkg::IDX_CPR)    ||
                    (idx == degd_pkg::IDX_LIMIT)  ||
                    (idx == degd_pkg::IDX_TC)     ||
                    (idx == degd_pkg::IDX_SWCLR)  ||
                    (idx == degd_pkg::IDX_REVS)   ||
                    (idx == degd_pkg::IDX_CTRL)   ||
                    (idx == degd_pkg::IDX_STAT)   ||
                    (idx == degd_pkg::IDX_ACCERR) ||
                    (idx == degd_pkg::IDX_INSTDV) ||
                    (idx == degd_pkg::IDX_MONDEV) ||
                    (idx == degd_pkg::IDX_POSERR);
  assign alarm_clr = wr_acc && (idx == degd_pkg::IDX_STAT) &&
                     apb_in.pwdata[degd_pkg::STAT_ALARM];

  always_comb begin
    cpr_d    = cpr_q;
    limit_d  = limit_q;
    tc_d     = tc_q;
    swclr_d  = swclr_q;
    revs_d   = revs_q;
    full_en_d = full_en_q;
    index_d  = index_q;
    prdata_d = prdata_q;
    slverr_d = 1'b0;
    if (wr_acc) begin
      if (idx == degd_pkg::IDX_CPR) begin
        cpr_d = apb_in.pwdata;
      end else if (idx == degd_pkg::IDX_LIMIT) begin
        limit_d = apb_in.pwdata;
      end else if (idx == degd_pkg::IDX_TC) begin
        tc_d = apb_in.pwdata[15:0];
      end else if (idx == degd_pkg::IDX_SWCLR) begin
        swclr_d = apb_in.pwdata[15:0];
      end else if (idx == degd_pkg::IDX_REVS) begin
        revs_d = apb_in.pwdata[15:0];
      end else if (idx == degd_pkg::IDX_CTRL) begin
        full_en_d = apb_in.pwdata[degd_pkg::CTRL_FULL_EN];
        index_d   = apb_in.pwdata[degd_pkg::CTRL_INDEX];
      end
    end
    if (rd_setup) begin
      slverr_d = ~mapped;
      prdata_d = 32'h0000_0000;
      if (idx == degd_pkg::IDX_CPR) begin
        prdata_d = cpr_q;
      end else if (idx == degd_pkg::IDX_LIMIT) begin
        prdata_d = limit_q;
      end else if (idx == degd_pkg::IDX_TC) begin
        prdata_d = {16'h0000, tc_q};
      end else if (idx == degd_pkg::IDX_SWCLR) begin
        prdata_d = {16'h0000, swclr_q};
      end else if (idx == degd_pkg::IDX_REVS) begin
        prdata_d = {16'h0000, revs_q};
      end else if (idx == degd_pkg::IDX_CTRL) begin
        prdata_d = {30'h0000_0000, index_q, full_en_q};
      end else if (idx == degd_pkg::IDX_STAT) begin
        prdata_d = {30'h0000_0000, full_loop_active_out, alarm_q};
      end else if (idx == degd_pkg::IDX_ACCERR) begin
        prdata_d = acc_err_q;
      end else if (idx == degd_pkg::IDX_INSTDV) begin
        prdata_d = inst_q;
      end else if (idx == degd_pkg::IDX_MONDEV) begin
        prdata_d = mon_q;
      end else if (idx == degd_pkg::IDX_POSERR) begin
        prdata_d = perr_q;
      end
    end
  end

  assign pready_out  = 1'b1;
  assign pslverr_out = slverr_q & apb_in.psel & apb_in.penable;
  assign prdata_out  = prdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // deviation, revolution clearing, alarm, loop switching, blending
  assign prod        = 64'($signed(enc_in.main_pos)) *
                       64'($signed({1'b0, cpr_q}));
  assign scaled_main = 32'(prod >>> degd_pkg::REV_SHIFT);
  assign dev         = scaled_main - enc_in.aux_pos;
  assign revs_done   = abs32(enc_in.main_pos - rev_ref_q) >>
                       degd_pkg::REV_SHIFT;
  assign rev_hit     = (revs_q != 16'h0000) &&
                       (revs_done >= {16'h0000, revs_q});
  assign want_full   = full_en_q & ~loop_select_in;
  assign sw_any      = want_full != full_loop_active_out;
  assign sw_up       = sw_any & want_full;
  assign clr_sw      = index_q ? sw_any :
                       (sw_up & ~swclr_q[degd_pkg::SWCLR_X]);

  always_comb begin
    loop_d     = want_full ? degd_pkg::DEGD_LOOP_FULL :
                             degd_pkg::DEGD_LOOP_HALF;
    dev_base_d = dev_base_q;
    rev_ref_d  = rev_ref_q;
    mon_d      = dev - dev_base_q;
    if (rev_hit) begin
      dev_base_d = dev;
      rev_ref_d  = enc_in.main_pos;
      mon_d      = 32'sh0000_0000;
    end
    // homing leaves the monitored deviation untouched
    acc_base_d = acc_base_q;
    acc_err_d  = enc_in.cmd_pos - enc_in.aux_pos - acc_base_q;
    if (homing_in) begin
      acc_base_d = enc_in.cmd_pos - enc_in.aux_pos;
      acc_err_d  = 32'sh0000_0000;
    end
    inst_d  = dev;
    // set wins over software clear
    alarm_d = (alarm_q & ~alarm_clr) |
              (abs32(mon_q) > limit_q);
    tick_d  = (tick_q >= TICK_CYCLES - 1) ? 32'h0000_0000 : tick_q + 32'h1;
    lpf_d   = lpf_q;
    if (!want_full || tc_q == 16'h0000) begin
      lpf_d = dev;
    end else if (tick_q == 32'h0000_0000) begin
      lpf_d = lpf_q + (dev - lpf_q) / $signed({16'h0000, tc_q});
    end
    if (!want_full) begin
      fb_d = scaled_main;
    end else if (tc_q == 16'h0000) begin
      fb_d = enc_in.aux_pos;
    end else begin
      fb_d = scaled_main - lpf_q;
    end
    vel_d     = scaled_main;
    err_ofs_d = err_ofs_q;
    perr_d    = enc_in.cmd_pos - fb_d - err_ofs_q;
    if (clr_sw || homing_in) begin
      err_ofs_d = enc_in.cmd_pos - fb_d;
      perr_d    = 32'sh0000_0000;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      cpr_q      <= degd_pkg::RST_CPR;
      limit_q    <= degd_pkg::RST_LIMIT;
      tc_q       <= degd_pkg::RST_TC;
      swclr_q    <= degd_pkg::RST_SWCLR;
      revs_q     <= degd_pkg::RST_REVS;
      full_en_q  <= 1'b0;
      index_q    <= 1'b0;
      alarm_q    <= 1'b0;
      prdata_q   <= 32'h0000_0000;
      slverr_q   <= 1'b0;
      loop_q     <= degd_pkg::DEGD_LOOP_HALF;
      dev_base_q <= 32'sh0000_0000;
      rev_ref_q  <= 32'sh0000_0000;
      mon_q      <= 32'sh0000_0000;
      acc_base_q <= 32'sh0000_0000;
      acc_err_q  <= 32'sh0000_0000;
      inst_q     <= 32'sh0000_0000;
      tick_q     <= 32'h0000_0000;
      lpf_q      <= 32'sh0000_0000;
      fb_q       <= 32'sh0000_0000;
      vel_q      <= 32'sh0000_0000;
      err_ofs_q  <= 32'sh0000_0000;
      perr_q     <= 32'sh0000_0000;
    end else begin
      cpr_q      <= cpr_d;
      limit_q    <= limit_d;
      tc_q       <= tc_d;
      swclr_q    <= swclr_d;
      revs_q     <= revs_d;
      full_en_q  <= full_en_d;
      index_q    <= index_d;
      alarm_q    <= alarm_d;
      prdata_q   <= prdata_d;
      slverr_q   <= slverr_d;
      loop_q     <= loop_d;
      dev_base_q <= dev_base_d;
      rev_ref_q  <= rev_ref_d;
      mon_q      <= mon_d;
      acc_base_q <= acc_base_d;
      acc_err_q  <= acc_err_d;
      inst_q     <= inst_d;
      tick_q     <= tick_d;
      lpf_q      <= lpf_d;
      fb_q       <= fb_d;
      vel_q      <= vel_d;
      err_ofs_q  <= err_ofs_d;
      perr_q     <= perr_d;
    end
  end

  assign excess_deviation_alarm_out = alarm_q;
  assign full_loop_active_out       = (loop_q == degd_pkg::DEGD_LOOP_FULL);
  assign pos_fb_out                 = fb_q;
  assign vel_fb_out                 = vel_q;
  assign pos_err_out                = perr_q;

  ////////////////////////////////////////////////////////////////////////////
  property p_alarm_rise;
    @(posedge clk_in) disable iff (sys_rst_in)
      (abs32(mon_q) > limit_q) |=> alarm_q;
  endproperty
  a_alarm_rise: assert property (p_alarm_rise)
    else $error("alarm missed an excessive deviation");

  property p_alarm_quiet;
    @(posedge clk_in) disable iff (sys_rst_in)
      (!alarm_q && abs32(mon_q) <= limit_q) |=> !alarm_q;
  endproperty
  a_alarm_quiet: assert property (p_alarm_quiet)
    else $error("alarm rose without excessive deviation");

  property p_inst_dev;
    @(posedge clk_in) disable iff (sys_rst_in)
      1'b1 |=> inst_q == $past(scaled_main) - $past(enc_in.aux_pos);
  endproperty
  a_inst_dev: assert property (p_inst_dev)
    else $error("instantaneous deviation formula wrong");

  property p_rev_clear;
    @(posedge clk_in) disable iff (sys_rst_in)
      rev_hit |=> (mon_q == 32'sh0000_0000) ##1
                  (mon_q == $past(dev) - $past(dev, 2));
  endproperty
  a_rev_clear: assert property (p_rev_clear)
    else $error("monitored deviation not restarted after revolutions");

  property p_rev_off;
    @(posedge clk_in) disable iff (sys_rst_in)
      (revs_q == 16'h0000) |-> (rev_ref_d == rev_ref_q) &&
                               (dev_base_d == dev_base_q);
  endproperty
  a_rev_off: assert property (p_rev_off)
    else $error("revolution clear fired while disabled");

  property p_homing;
    @(posedge clk_in) disable iff (sys_rst_in)
      (homing_in && !rev_hit) |=>
        (acc_err_q == 32'sh0000_0000) &&
        (mon_q == $past(dev) - $past(dev_base_q));
  endproperty
  a_homing: assert property (p_homing)
    else $error("homing handled errors wrongly");

  property p_bypass;
    @(posedge clk_in) disable iff (sys_rst_in)
      (want_full && tc_q == 16'h0000) |=> fb_q == $past(enc_in.aux_pos);
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("zero time constant did not bypass the filter");

  property p_half_fb;
    @(posedge clk_in) disable iff (sys_rst_in)
      !want_full |=> (fb_q == $past(scaled_main)) && !full_loop_active_out;
  endproperty
  a_half_fb: assert property (p_half_fb)
    else $error("half-closed loop not on motor encoder");

  property p_sw_clear;
    @(posedge clk_in) disable iff (sys_rst_in)
      (sw_up && !swclr_q[degd_pkg::SWCLR_X]) |=> perr_q == 32'sh0000_0000;
  endproperty
  a_sw_clear: assert property (p_sw_clear)
    else $error("error not cleared on switch to full loop");

  property p_sw_keep;
    @(posedge clk_in) disable iff (sys_rst_in)
      (sw_up && swclr_q[degd_pkg::SWCLR_X] && !index_q && !homing_in)
        |=> $stable(err_ofs_q);
  endproperty
  a_sw_keep: assert property (p_sw_keep)
    else $error("error dropped although keep was selected");

  property p_index_clear;
    @(posedge clk_in) disable iff (sys_rst_in)
      (sw_any && index_q) |=> perr_q == 32'sh0000_0000;
  endproperty
  a_index_clear: assert property (p_index_clear)
    else $error("indexing mode did not clear error on switch");

endmodule : degd_guard

`default_nettype wire

// [design/degd_unused_placeholder.sv]
// degd_unused_placeholder: holds no logic of its own
// assumes: every part of the guard lives in degd_guard

// [tb/degd_enc_model.sv]
// degd_enc_model: motor and load encoder pair facing the guard
// assumes: motion, slip and command set by the bench, clk_in domain
`timescale 1ns/100ps
`default_nettype none

module degd_enc_model (
  input  wire logic               clk_in,
  input  wire logic               sys_rst_in,
  input  wire logic signed [31:0] step_in,
  input  wire logic signed [31:0] slip_in,
  input  wire logic signed [31:0] cmd_in,
  output var degd_pkg::degd_enc_s enc_out
);
  logic signed [31:0] main_q;

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      main_q <= 32'sh0;
    end else begin
      main_q <= main_q + step_in;
    end
  end

  // load units per rev equal motor counts per rev at a 1:1 gear
  assign enc_out = '{main_pos: main_q,
                     aux_pos:  main_q - slip_in,
                     cmd_pos:  cmd_in};
endmodule // degd_enc_model
`default_nettype wire

// [tb/tb_top.sv]
// tb_top: self-checking bench for the deviation guard
// assumes: apb master and encoder model on one 100 MHz clock
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  typedef struct packed {logic w; logic [31:0] d; logic e;} degd_exp_s;

  logic                    clk_in;
  logic                    sys_rst_in;
  degd_pkg::degd_apb_req_s apb;
  degd_pkg::degd_enc_s     enc;
  logic                    pready;
  logic                    pslverr;
  logic                    alarm;
  logic                    full;
  logic                    loop_sel;
  logic                    homing;
  logic [31:0]             prdata;
  logic signed [31:0]      pos_fb;
  logic signed [31:0]      vel_fb;
  logic signed [31:0]      pos_err;
  logic signed [31:0]      step;
  logic signed [31:0]      slip;
  logic signed [31:0]      cmd;
  logic signed [63:0]      wide;
  logic [31:0]             r;
  degd_exp_s               ex;
  degd_exp_s               exp_q[$];
  int                      miscompares;
  int                      compares;

  degd_guard #(.TICK_CYCLES(10)) u_degd_guard (
    .clk_in                     (clk_in),
    .sys_rst_in                 (sys_rst_in),
    .apb_in                     (apb),
    .pready_out                 (pready),
    .pslverr_out                (pslverr),
    .prdata_out                 (prdata),
    .enc_in                     (enc),
    .loop_select_in             (loop_sel),
    .homing_in                  (homing),
    .excess_deviation_alarm_out (alarm),
    .full_loop_active_out       (full),
    .pos_fb_out                 (pos_fb),
    .vel_fb_out                 (vel_fb),
    .pos_err_out                (pos_err)
  );

  degd_enc_model u_degd_enc_model (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .step_in    (step),
    .slip_in    (slip),
    .cmd_in     (cmd),
    .enc_out    (enc)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chkb(input string nm, input logic e, input logic g);
    chk(nm, {31'h0, e}, {31'h0, g});
  endtask

  task automatic bus(input logic w, input logic [9:0] idx,
                     input logic [31:0] d, input logic e);
    exp_q.push_back(degd_exp_s'{w, d, e});
    @(posedge clk_in);
    apb <= '{1'b1, 1'b0, w, {idx, 2'b00}, d};
    @(posedge clk_in);
    apb.penable <= 1'b1;
    do @(posedge clk_in); while (pready !== 1'b1);
    apb.psel    <= 1'b0;
    apb.penable <= 1'b0;
  endtask

  task automatic go(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  task automatic give_verdict();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_in) begin
    if (apb.psel && apb.penable && pready === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk("queue", 32'h1, 32'h0);
      end else begin
        ex = exp_q.pop_front();
        chkb("pslverr", ex.e, pslverr);
        if (!ex.w) chk("prdata", ex.d, prdata);
      end
    end
  end

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  initial begin
    #500000;
    miscompares++;
    give_verdict();
  end

  initial begin
    void'($urandom(23));
    sys_rst_in  = 1'b1;
    apb         = '0;
    step        = 32'sh0;
    slip        = 32'sh0;
    cmd         = 32'sh0;
    loop_sel    = 1'b1;
    homing      = 1'b0;
    miscompares = 0;
    compares    = 0;
    repeat (8) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    // defaults, unmapped word, random readback
    bus(0, degd_pkg::IDX_LIMIT, 32'h0000_7530, 0);
    bus(0, degd_pkg::IDX_TC, 32'h0000_0064, 0);
    bus(0, degd_pkg::IDX_SWCLR, 32'h0, 0);
    bus(0, 10'h3FF, 32'h0, 1);
    bus(1, 10'h3FF, 32'hFFFF_FFFF, 1);
    r = $urandom & 32'h7FFF_FFFF;
    bus(1, degd_pkg::IDX_LIMIT, r, 0);
    bus(0, degd_pkg::IDX_LIMIT, r, 0);
    bus(1, degd_pkg::IDX_LIMIT, 32'h64, 0);
    // scaled deviation with half a load rev per motor rev
    @(posedge clk_in);
    step <= 32'sh3039 + ($urandom % 256);
    repeat (3) @(posedge clk_in);
    step <= 32'sh0;
    bus(1, degd_pkg::IDX_CPR, 32'h0080_0000, 0);
    go(3);
    chkb("alarm", 1'b1, alarm);
    wide = ((64'(enc.main_pos) * 64'sh80_0000) >>> 24) - enc.aux_pos;
    bus(0, degd_pkg::IDX_INSTDV, wide[31:0], 0);
    bus(1, degd_pkg::IDX_CPR, 32'h0100_0000, 0);
    bus(1, degd_pkg::IDX_STAT, 32'h1, 0);
    // alarm on magnitude above limit, both signs
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_in);
      slip <= i ? -32'sh64 : 32'sh64;
      go(4);
      chkb("alarm", 1'b0, alarm);
      @(posedge clk_in);
      slip <= (i ? -32'sh1 : 32'sh1) * (32'sh65 + ($urandom % 16));
      go(3);
      chkb("alarm", 1'b1, alarm);
      @(posedge clk_in);
      slip <= 32'sh0;
      go(2);
      bus(1, degd_pkg::IDX_STAT, 32'h1, 0);
      go(2);
      chkb("alarm", 1'b0, alarm);
    end
    // monitors and homing
    @(posedge clk_in);
    slip <= 32'sh28;
    go(3);
    bus(0, degd_pkg::IDX_MONDEV, 32'h28, 0);
    @(posedge clk_in);
    homing <= 1'b1;
    @(posedge clk_in);
    homing <= 1'b0;
    go(2);
    chk("pos_err", 32'h0, pos_err);
    bus(0, degd_pkg::IDX_ACCERR, 32'h0, 0);
    bus(0, degd_pkg::IDX_INSTDV, 32'h28, 0);
    bus(0, degd_pkg::IDX_MONDEV, 32'h28, 0);
    // revolution clearing
    bus(1, degd_pkg::IDX_LIMIT, 32'h7FFF_FFFF, 0);
    bus(1, degd_pkg::IDX_REVS, 32'h1, 0);
    @(posedge clk_in);
    step <= 32'sh0040_0000;
    repeat (40) @(posedge clk_in);
    step <= 32'sh0;
    go(3);
    bus(0, degd_pkg::IDX_MONDEV, 32'h0, 0);
    // loop selection
    @(posedge clk_in);
    loop_sel <= 1'b0;
    go(3);
    chkb("full", 1'b0, full);
    bus(1, degd_pkg::IDX_CTRL, 32'h1, 0);
    go(3);
    chkb("full", 1'b1, full);
    chk("pos_err", 32'h0, pos_err);
    bus(0, degd_pkg::IDX_STAT, 32'h2, 0);
    #1;
    chk("vel_fb", enc.main_pos, vel_fb);
    chk("pos_fb", enc.aux_pos, pos_fb);
    // blending and bypass
    bus(1, degd_pkg::IDX_TC, 32'h3E8, 0);
    @(posedge clk_in);
    slip <= 32'sh154;
    go(3);
    chk("pos_fb", enc.main_pos - 32'sh28, pos_fb);
    bus(1, degd_pkg::IDX_TC, 32'h0, 0);
    go(2);
    chk("pos_fb", enc.aux_pos, pos_fb);
    // error kept on switch
    @(posedge clk_in);
    loop_sel <= 1'b1;
    go(3);
    @(posedge clk_in);
    homing <= 1'b1;
    @(posedge clk_in);
    homing <= 1'b0;
    cmd    <= 32'sh3E8;
    go(3);
    chk("pos_err", 32'h3E8, pos_err);
    bus(1, degd_pkg::IDX_SWCLR, 32'h1, 0);
    @(posedge clk_in);
    loop_sel <= 1'b0;
    go(3);
    chk("pos_err", 32'h53C, pos_err);
    // indexing clears on both switches
    bus(1, degd_pkg::IDX_CTRL, 32'h3, 0);
    @(posedge clk_in);
    loop_sel <= 1'b1;
    go(3);
    chk("pos_err", 32'h0, pos_err);
    @(posedge clk_in);
    cmd <= 32'sh7D0;
    go(2);
    @(posedge clk_in);
    loop_sel <= 1'b0;
    go(3);
    chk("pos_err", 32'h0, pos_err);
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire
